// ### design/ch1_frame_irq_enable_set.sv
// Channel 1 frame interrupt arm flag with its register port and event interrupt
`timescale 1ns/1ps
`include "ch1_arm_params.svh"

module ch1_frame_irq_enable_set
	import ch1_arm_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	// Register port
	input  wire logic [`ADDR_W-1:0]  regAddr,
	input  wire logic [31:0]         regWdata,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	output logic      [31:0]         regRdata,
	// Mode, arm flag and gated enables
	input  wire logic                rawMode,
	output logic                     ch1FrameIrqArm,
	output logic                     ch1LineIrqEnable,
	output logic                     ch1FrameIrqEnable,
	// Interrupt
	output logic                     irq
);
	logic        masterEnable_reg;
	logic        armed_reg;
	logic [31:0] chan0Control_reg;
	logic [`ST_W-1:0] status_reg;
	logic [`ST_W-1:0] mask_reg;
	logic [31:0] rdata_reg;
	logic        lineEn_reg;
	logic        frameEn_reg;
	logic        irq_reg;
	logic        armed_next;
	logic [`ST_W-1:0] status_next;
	logic [31:0] rdata_next;

	wire selMaster  = (regAddr == `OFS_MASTER_ENABLE);
	wire selSet     = (regAddr == `OFS_ENABLE_SET);
	wire selClear   = (regAddr == `OFS_ENABLE_CLEAR);
	wire selCtrl    = (regAddr == `OFS_CHAN0_CONTROL);
	wire selStatus  = (regAddr == `OFS_IRQ_STATUS);
	wire selMask    = (regAddr == `OFS_IRQ_MASK);

	wire armWrite    = regWrite && selSet && regWdata[`BIT_CH1];
	wire disarmWrite = regWrite && selClear && regWdata[`BIT_CH1];
	wire armTake     = armWrite && masterEnable_reg;
	wire armIgnore   = armWrite && !masterEnable_reg;
	wire disarmTake  = disarmWrite && armed_reg;

	wire [`FMT_W-1:0] fmt = chan0Control_reg[`FMT_LSB +: `FMT_W];
	// In raw mode, other format codes leave both gated enables off rather than guess a meaning
	wire gate_sel_t gateSel = (!rawMode) ? GATE_FRAME :
		(fmt == `FMT_LINE) ? GATE_LINE :
		(fmt == `FMT_FRAME) ? GATE_FRAME : GATE_NONE;

	// Disarm beats a same-cycle arm; arm holds otherwise
	assign armed_next = disarmTake ? 1'b0 :
		armTake ? 1'b1 : armed_reg;

	wire [`ST_W-1:0] stEvents = {armIgnore, disarmTake, armTake};
	wire [`ST_W-1:0] stClear  = (regWrite && selStatus) ? regWdata[`ST_W-1:0] : '0;
	// Set wins over clear so an event in the clearing cycle is kept
	assign status_next = (status_reg & ~stClear) | stEvents;

	assign rdata_next =
		!regRead ? `RST_WORD :
		selMaster ? {30'h0, masterEnable_reg, 1'b0} :
		selSet    ? {30'h0, armed_reg, 1'b0} :
		selCtrl   ? chan0Control_reg :
		selStatus ? {29'h0, status_reg} :
		selMask   ? {29'h0, mask_reg} : `RST_WORD;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			masterEnable_reg <= 1'b0;
			armed_reg        <= 1'b0;
			chan0Control_reg <= `RST_WORD;
			status_reg       <= '0;
			mask_reg         <= '0;
			rdata_reg        <= `RST_WORD;
			lineEn_reg       <= 1'b0;
			frameEn_reg      <= 1'b0;
			irq_reg          <= 1'b0;
		end else begin
			if (regWrite && selMaster) begin
				masterEnable_reg <= regWdata[`BIT_CH1];
			end
			if (regWrite && selCtrl) begin
				chan0Control_reg <= regWdata;
			end
			if (regWrite && selMask) begin
				mask_reg <= regWdata[`ST_W-1:0];
			end
			armed_reg   <= armed_next;
			status_reg  <= status_next;
			rdata_reg   <= rdata_next;
			lineEn_reg  <= armed_next && (gateSel == GATE_LINE);
			frameEn_reg <= armed_next && (gateSel == GATE_FRAME);
			irq_reg     <= |(status_next & mask_reg);
		end
	end

	assign regRdata          = rdata_reg;
	assign ch1FrameIrqArm    = armed_reg;
	assign ch1LineIrqEnable  = lineEn_reg;
	assign ch1FrameIrqEnable = frameEn_reg;
	assign irq               = irq_reg;
endmodule

// ### design/ch1_arm_params.svh
// Register offsets, field positions and reset values of the channel 1 arm block
`ifndef CH1_ARM_PARAMS_SVH
`define CH1_ARM_PARAMS_SVH

`define ADDR_W              8
`define OFS_MASTER_ENABLE   8'h00
`define OFS_ENABLE_SET      8'h04
`define OFS_ENABLE_CLEAR    8'h08
`define OFS_CHAN0_CONTROL   8'h0c
`define OFS_IRQ_STATUS      8'h10
`define OFS_IRQ_MASK        8'h14
`define BIT_CH1             1
`define FMT_LSB             0
`define FMT_W               2
`define FMT_LINE            2'h3
`define FMT_FRAME           2'h0
`define BIT_ST_ARMED        0
`define BIT_ST_DISARMED     1
`define BIT_ST_IGNORED      2
`define ST_W                3
`define RST_WORD            32'h00000000

`endif

// ### design/ch1_arm_pkg.sv
// Types shared by the channel 1 arm block
package ch1_arm_pkg;
	typedef enum logic [1:0] {
		GATE_FRAME = 2'b00,
		GATE_LINE  = 2'b01,
		GATE_NONE  = 2'b10
	} gate_sel_t;
endpackage

// ### dv/ch1_arm_checker.sv
// Port assertions for the channel 1 arm flag
`timescale 1ns/1ps
`include "ch1_arm_params.svh"
module ch1_arm_checker (
	// Watched ports
	input wire logic                ref_clk, rst_n, regWrite, regRead, rawMode,
	input wire logic [`ADDR_W-1:0]  regAddr,
	input wire logic [31:0]         regWdata, regRdata,
	input wire logic                ch1FrameIrqArm, ch1LineIrqEnable, ch1FrameIrqEnable
);
	logic masterReg;
	wire setW = regWrite && regAddr == `OFS_ENABLE_SET;
	wire clrW = regWrite && regAddr == `OFS_ENABLE_CLEAR && regWdata[1];
	// Shadow of master enable, since the checker cannot see inside
	always_ff @(posedge ref_clk)
		if (!rst_n) masterReg <= 1'b0;
		else if (regWrite && regAddr == `OFS_MASTER_ENABLE) masterReg <= regWdata[1];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_arm_holds: assert property (ch1FrameIrqArm && !clrW |=> ch1FrameIrqArm)
		else $error("arm flag dropped");
	a_arm_ignored: assert property (setW && !masterReg && !ch1FrameIrqArm |=> !ch1FrameIrqArm)
		else $error("arm taken without master");
	a_zero_write: assert property (setW && !regWdata[1] |=> $stable(ch1FrameIrqArm))
		else $error("zero write moved arm");
	a_disarm_clears: assert property (clrW |=> !ch1FrameIrqArm)
		else $error("disarm ignored");
	a_line_gate: assert property (ch1LineIrqEnable |-> ch1FrameIrqArm && !ch1FrameIrqEnable)
		else $error("line gate wrong");
	a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> !ch1FrameIrqArm)
		else $error("arm after reset");
	a_arm_readback: assert property (regRead && regAddr == `OFS_ENABLE_SET
		|=> regRdata == {30'h0, ch1FrameIrqArm, 1'b0})
		else $error("readback wrong");
endmodule
bind ch1_frame_irq_enable_set ch1_arm_checker u_chk (.*);

// ### dv/tb_ch1_frame_irq_enable_set.sv
// Self-checking bench of the channel 1 arm flag
`timescale 1ns/1ps
`include "ch1_arm_params.svh"
module tb_ch1_frame_irq_enable_set;
	logic ref_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, rawMode = 0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic arm, lineEn, frameEn, irq;
	int err_count = 0, n_compared = 0, seed = 7252;
	always #12.5 ref_clk = ~ref_clk;
	ch1_frame_irq_enable_set u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.rawMode(rawMode), .ch1FrameIrqArm(arm), .ch1LineIrqEnable(lineEn),
		.ch1FrameIrqEnable(frameEn), .irq(irq));
	function logic [31:0] gate(input int f);
		return f == 3 ? 32'h2 : f == 0 ? 32'h1 : 32'h0;
	endfunction
	task c(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task w(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		#1;
	endtask
	task r(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		c(regRdata, e);
	endtask
	task tally_and_finish;
		$display("errors=%0d compared=%0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#100us;
		err_count++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		c(32'(arm), 32'h0);
		w(`OFS_IRQ_MASK, 32'h7);
		w(`OFS_ENABLE_SET, 32'h2);
		r(`OFS_ENABLE_SET, 32'h0);
		r(`OFS_IRQ_STATUS, 32'h4);
		c(32'(irq), 32'h1);
		w(`OFS_IRQ_STATUS, 32'h7);
		c(32'(irq), 32'h0);
		w(`OFS_MASTER_ENABLE, 32'h2);
		repeat (8) begin
			w(`OFS_ENABLE_SET, $random(seed) & 32'hfffffffd);
			c(32'(arm), 32'h0);
		end
		w(`OFS_ENABLE_SET, 32'h2);
		w(`OFS_ENABLE_SET, 32'h0);
		r(`OFS_ENABLE_SET, 32'h2);
		c({30'h0, lineEn, frameEn}, 32'h1);
		@(posedge ref_clk);
		rawMode <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			w(`OFS_CHAN0_CONTROL, 32'(f));
			@(posedge ref_clk);
			#1;
			c({30'h0, lineEn, frameEn}, gate(f));
		end
		w(`OFS_ENABLE_CLEAR, 32'h2);
		c(32'(arm), 32'h0);
		r(`OFS_IRQ_STATUS, 32'h3);
		c(32'(irq), 32'h1);
		r(`OFS_ENABLE_CLEAR, 32'h0);
		r(8'h40, 32'h0);
		tally_and_finish;
	end
endmodule
